// ### hw/sar_cfg.svh
// timing, width and reset constants of the converter readout block
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

`define SAR_CLK_MHZ          200
`define SAR_SAMPLE_W         14
`define SAR_WORD_W           24
`define SAR_ACC_MAX          1024
`define SAR_RECAL_PULSES     1024
`define SAR_CONV_PHASE_NS    700
`define SAR_CONV_PHASE_CYC   ((`SAR_CONV_PHASE_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_CAL_TIME_MS      500
`define SAR_CAL_CYC          (`SAR_CAL_TIME_MS * `SAR_CLK_MHZ * 1000)
`define SAR_SDO_RST          1'b0
`define SAR_SDO_OE_N_RST     1'b1

`endif

// ### hw/sar_pkg.sv
// types shared by the converter readout block
package sar_pkg;

    typedef enum logic [2:0] {
        SAR_ACQ  = 3'b001,
        SAR_CONV = 3'b010,
        SAR_CAL  = 3'b100
    } sar_state_t;

    typedef struct packed {
        logic conv;
        logic sclk;
        logic mode;
    } sar_pins_t;

endpackage : sar_pkg

// ### hw/sar_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module sar_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : sar_sync

// ### hw/sar_readout.sv
// serial control and readout of a differential SAR converter
`timescale 1ns/10ps
`include "sar_cfg.svh"

module sar_readout
    import sar_pkg::*;
#(
    parameter int SAMPLE_W = `SAR_SAMPLE_W,
    parameter int WORD_W   = `SAR_WORD_W,
    parameter int ACC_MAX  = `SAR_ACC_MAX,
    parameter int CONV_CYC = `SAR_CONV_PHASE_CYC,
    parameter int CAL_CYC  = `SAR_CAL_CYC
) (
    // clock and reset
    input  wire logic                core_clk_in,
    input  wire logic                rst_n_in,
    // serial link pins
    input  wire logic                conversion_strobe_in,
    input  wire logic                sclk_in,
    input  wire logic                mode_select_in,
    output logic                     serial_data_out,
    output logic                     serial_data_oe_n_out,
    // converter core
    input  wire logic [SAMPLE_W-1:0] sample_code_in,
    output logic                     converting_out,
    output logic                     calibrating_out
);

    // one timer serves both phases, so size it for the longer one
    localparam int TMR_MAX = (CAL_CYC > CONV_CYC) ? CAL_CYC : CONV_CYC;
    localparam int TMR_W   = $clog2(TMR_MAX + 1);

    sar_pins_t             pins_raw;
    sar_pins_t             pins_s;
    sar_pins_t             pins_q_r;
    sar_state_t            state_r;
    logic [TMR_W-1:0]      timer_r;
    logic                  busy_mode_r;
    logic                  fresh_r;
    logic                  sclk_seen_r;
    logic [WORD_W-1:0]     acc_r;
    logic [10:0]           nsamp_r;
    logic [4:0]            width_r;
    logic [WORD_W-1:0]     shreg_r;
    logic [4:0]            fall_cnt_r;
    logic                  word_live_r;
    logic                  busy_pend_r;
    logic [10:0]           recal_cnt_r;
    logic                  conv_rise;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  conv_done;
    logic                  cal_done;
    logic                  driving;
    logic [WORD_W-1:0]     sext;
    logic [WORD_W-1:0]     acc_nxt;
    logic [10:0]           nsamp_nxt;
    logic [4:0]            width_nxt;
    logic                  sdo_nxt;
    logic                  oe_n_nxt;

    // output word length for n accumulated samples
    function automatic logic [4:0] word_width(input logic [10:0] n);
        logic [10:0] m;
        logic [4:0]  w;
        m = n - 11'd1;
        w = 5'(SAMPLE_W);
        for (int i = 0; i < 10; i++) begin
            if ((m >> i) != 11'd0) begin
                w = 5'(SAMPLE_W + 1 + i);
            end
        end
        return w;
    endfunction : word_width

    assign pins_raw.conv = conversion_strobe_in;
    assign pins_raw.sclk = sclk_in;
    assign pins_raw.mode = mode_select_in;

    sar_sync #(
        .W ($bits(sar_pins_t))
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .async_in    (pins_raw),
        .sync_out    (pins_s)
    );

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pins_q_r <= '0;
        end else begin
            pins_q_r <= pins_s;
        end
    end

    assign conv_rise = pins_s.conv & ~pins_q_r.conv;
    assign sclk_rise = pins_s.sclk & ~pins_q_r.sclk;
    assign sclk_fall = ~pins_s.sclk & pins_q_r.sclk;
    assign conv_done = (state_r == SAR_CONV) && (timer_r == '0);
    assign cal_done  = (state_r == SAR_CAL) && (timer_r == '0);

    // accumulate or restart on conversion end
    always_comb begin
        sext = {{(WORD_W - SAMPLE_W){sample_code_in[SAMPLE_W-1]}},
                sample_code_in};
        if (fresh_r || nsamp_r == 11'(ACC_MAX)) begin
            acc_nxt   = sext;
            nsamp_nxt = 11'd1;
        end else begin
            acc_nxt   = acc_r + sext;
            nsamp_nxt = nsamp_r + 11'd1;
        end
        width_nxt = word_width(nsamp_nxt);
    end

    // phase sequencing
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= SAR_ACQ;
            timer_r <= '0;
        end else begin
            case (state_r)
                SAR_ACQ: begin
                    if (conv_rise) begin
                        state_r <= SAR_CONV;
                        timer_r <= TMR_W'(CONV_CYC - 1);
                    end else if (sclk_rise &&
                                 recal_cnt_r == 11'(`SAR_RECAL_PULSES - 1)) begin
                        state_r <= SAR_CAL;
                        timer_r <= TMR_W'(CAL_CYC - 1);
                    end
                end
                SAR_CONV: begin
                    // strobe ignored here so the line can select others
                    if (conv_done) begin
                        state_r <= SAR_ACQ;
                    end else begin
                        timer_r <= timer_r - 1'b1;
                    end
                end
                SAR_CAL: begin
                    if (cal_done) begin
                        state_r <= SAR_ACQ;
                    end else begin
                        timer_r <= timer_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= SAR_ACQ;
                    timer_r <= '0;
                end
            endcase
        end
    end

    // recalibration request counter, one acquisition phase only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            recal_cnt_r <= '0;
        end else if (conv_rise || state_r != SAR_ACQ) begin
            recal_cnt_r <= '0;
        end else if (sclk_rise) begin
            recal_cnt_r <= recal_cnt_r + 11'd1;
        end
    end

    // any clock pulse outside recalibration marks the stored result as read
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_seen_r <= 1'b0;
            fresh_r     <= 1'b1;
        end else begin
            if (cal_done) begin
                fresh_r <= 1'b1;
            end else if (state_r == SAR_ACQ && conv_rise) begin
                fresh_r <= sclk_seen_r | sclk_rise;
            end
            if (sclk_rise && state_r != SAR_CAL) begin
                sclk_seen_r <= 1'b1;
            end else if (state_r == SAR_ACQ && conv_rise) begin
                sclk_seen_r <= 1'b0;
            end
        end
    end

    // accumulator and mode latch
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_r       <= '0;
            nsamp_r     <= '0;
            width_r     <= 5'(SAMPLE_W);
            busy_mode_r <= 1'b0;
        end else begin
            if (state_r == SAR_ACQ && conv_rise) begin
                busy_mode_r <= ~pins_s.mode;
            end
            if (conv_done) begin
                acc_r   <= acc_nxt;
                nsamp_r <= nsamp_nxt;
                width_r <= width_nxt;
            end
        end
    end

    // no-busy words wait for the strobe to fall; busy words go at once
    assign driving = (state_r == SAR_ACQ) && word_live_r &&
                     (busy_mode_r || !pins_s.conv);

    // shift register: one bit per serial clock falling edge
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shreg_r     <= '0;
            fall_cnt_r  <= '0;
            word_live_r <= 1'b0;
            busy_pend_r <= 1'b0;
        end else if (conv_done) begin
            shreg_r     <= acc_nxt << (5'(WORD_W) - width_nxt);
            fall_cnt_r  <= '0;
            word_live_r <= 1'b1;
            busy_pend_r <= busy_mode_r;
        end else if (conv_rise || state_r != SAR_ACQ) begin
            word_live_r <= 1'b0;
            busy_pend_r <= 1'b0;
        end else if (driving && sclk_fall) begin
            if (busy_pend_r) begin
                busy_pend_r <= 1'b0;
            end else begin
                shreg_r    <= shreg_r << 1;
                fall_cnt_r <= fall_cnt_r + 5'd1;
                if (fall_cnt_r + 5'd1 == width_r) begin
                    word_live_r <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        sdo_nxt  = `SAR_SDO_RST;
        oe_n_nxt = `SAR_SDO_OE_N_RST;
        if (state_r == SAR_CAL) begin
            oe_n_nxt = 1'b0;
        end else if (driving && !(conv_rise || conv_done)) begin
            oe_n_nxt = 1'b0;
            sdo_nxt  = busy_pend_r ? 1'b0 : shreg_r[WORD_W-1];
        end
    end

    // pin driven from flops so it holds across both clock edges
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            serial_data_out      <= `SAR_SDO_RST;
            serial_data_oe_n_out <= `SAR_SDO_OE_N_RST;
        end else begin
            serial_data_out      <= sdo_nxt;
            serial_data_oe_n_out <= oe_n_nxt;
        end
    end

    assign converting_out  = state_r[1];
    assign calibrating_out = state_r[2];

endmodule : sar_readout

// ### bench/sar_readout_properties.sv
// port-level assertions for the converter readout block
`timescale 1ns/10ps
module sar_readout_properties
    import sar_pkg::*;
#(
    parameter int SAMPLE_W = 14,
    parameter int CONV_CYC = 140,
    parameter int CAL_CYC  = 200
) (
    // clock and reset
    input wire logic                core_clk_in,
    input wire logic                rst_n_in,
    // watched pins
    input wire logic                conversion_strobe_in,
    input wire logic                sclk_in,
    input wire logic                mode_select_in,
    input wire logic                serial_data_out,
    input wire logic                serial_data_oe_n_out,
    input wire logic [SAMPLE_W-1:0] sample_code_in,
    input wire logic                converting_out,
    input wire logic                calibrating_out
);
    int conv_cnt_r;
    int cal_cnt_r;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // length counters; a property delay cannot hold the long counts
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            conv_cnt_r <= 0;
        else
            conv_cnt_r <= converting_out ? conv_cnt_r + 1 : 0;
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            cal_cnt_r <= 0;
        else
            cal_cnt_r <= calibrating_out ? cal_cnt_r + 1 : 0;
    end

    strobe_starts_a: assert property ($rose(conversion_strobe_in)
        && !converting_out && !calibrating_out |-> ##[1:5] converting_out)
        else $error("strobe rise did not start a conversion");
    conv_float_a: assert property (converting_out
        && $past(converting_out) |-> serial_data_oe_n_out)
        else $error("line driven during conversion");
    conv_length_a: assert property ($fell(converting_out)
        |-> conv_cnt_r == CONV_CYC)
        else $error("conversion length wrong");
    busy_bit_a: assert property ($fell(converting_out)
        && !mode_select_in
        |-> ##[0:1] !serial_data_oe_n_out && !serial_data_out)
        else $error("busy bit missing");
    nobusy_float_a: assert property ((mode_select_in
        && !calibrating_out && conversion_strobe_in)[*4]
        |-> serial_data_oe_n_out)
        else $error("line driven while strobe high");
    cal_low_a: assert property (calibrating_out
        && $past(calibrating_out)
        |-> !serial_data_oe_n_out && !serial_data_out)
        else $error("line not low in recalibration");
    cal_length_a: assert property ($fell(calibrating_out)
        |-> cal_cnt_r == CAL_CYC)
        else $error("recalibration length wrong");
    cal_release_a: assert property ($fell(calibrating_out)
        |-> ##[0:2] serial_data_oe_n_out)
        else $error("line not released after recalibration");
    cal_no_conv_a: assert property (calibrating_out
        |-> !converting_out)
        else $error("conversion during recalibration");
    cal_on_clock_a: assert property ($rose(calibrating_out)
        |-> sclk_in)
        else $error("recalibration began without a clock pulse");

    cover property ($fell(calibrating_out));
    cover property ($fell(converting_out) && mode_select_in);
    cover property ($fell(converting_out) && !mode_select_in);
endmodule : sar_readout_properties

bind sar_readout sar_readout_properties #(
    .CONV_CYC(CONV_CYC), .CAL_CYC(CAL_CYC)) u_props (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .conversion_strobe_in(conversion_strobe_in), .sclk_in(sclk_in),
    .mode_select_in(mode_select_in), .serial_data_out(serial_data_out),
    .serial_data_oe_n_out(serial_data_oe_n_out),
    .sample_code_in(sample_code_in), .converting_out(converting_out),
    .calibrating_out(calibrating_out));

// ### bench/sar_host_model.sv
// host side model: strobe, serial clock and mode pins
`timescale 1ns/10ps
module sar_host_model
    import sar_pkg::*;
(
    // clock and line
    input  wire logic core_clk_in,
    input  wire logic sdo_line_in,
    // pins toward the device
    output sar_pins_t pins_out
);
    initial pins_out = '{1'b0, 1'b0, 1'b1};

    task automatic set_mode(input logic m);
        @(posedge core_clk_in);
        pins_out.mode <= m;
    endtask : set_mode

    // host alone starts conversions; hold sets early or late lowering
    task automatic convert(input int hold);
        @(posedge core_clk_in);
        pins_out.conv <= 1'b1;
        repeat (hold) @(posedge core_clk_in);
        pins_out.conv <= 1'b0;
    endtask : convert

    // 80 ns serial clock, bit taken at the end of the high phase
    task automatic shift_in(input int n, output logic [24:0] w);
        w = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_in);
            pins_out.sclk <= 1'b1;
            repeat (8) @(posedge core_clk_in);
            w = {w[23:0], sdo_line_in};
            pins_out.sclk <= 1'b0;
            repeat (7) @(posedge core_clk_in);
        end
    endtask : shift_in
endmodule : sar_host_model

// ### bench/testbench.sv
// self-checking bench for the converter readout block
`timescale 1ns/10ps
module testbench;
    import sar_pkg::*;
    localparam int CONV = 140; // default conversion length, left untied
    localparam int CAL  = 200;
    logic        core_clk_in;
    logic        rst_n_in;
    logic        sdo_data;
    logic        sdo_oe_n;
    logic        conv_busy;
    logic        cal_busy;
    logic [13:0] code;
    logic [24:0] w;
    sar_pins_t   pins;
    int          fail_count;
    int          n_compared;
    int          cyc;
    // pull-up on the data line
    wire         sdo_line = sdo_oe_n ? 1'b1 : sdo_data;

    sar_readout #(.CAL_CYC(CAL)) dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .conversion_strobe_in(pins.conv), .sclk_in(pins.sclk),
        .mode_select_in(pins.mode), .serial_data_out(sdo_data),
        .serial_data_oe_n_out(sdo_oe_n), .sample_code_in(code),
        .converting_out(conv_busy), .calibrating_out(cal_busy));
    sar_host_model host (.core_clk_in(core_clk_in), .sdo_line_in(sdo_line),
        .pins_out(pins));

    task automatic check(input logic [24:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    task automatic wait_idle;
        int k;
        repeat (4) @(posedge core_clk_in);
        for (k = 0; k < 500 && conv_busy !== 1'b0; k++)
            @(posedge core_clk_in);
        check(25'(k < 500), 25'd1, "conversion hang");
        repeat (3) @(posedge core_clk_in);
    endtask : wait_idle

    task automatic test_busy;
        host.set_mode(1'b0);
        code <= 14'h2A5C;
        host.convert(2);
        wait_idle();
        check(25'(sdo_line), 25'd0, "no busy bit");
        host.shift_in(15, w);
        check(w, 25'h2A5C, "busy word");
        repeat (4) @(posedge core_clk_in);
        check(25'(sdo_line), 25'd1, "no float at 15th fall");
        $display("busy mode done");
    endtask : test_busy

    task automatic test_nobusy;
        host.set_mode(1'b1);
        code <= 14'h2001;
        host.convert(CONV + 10);
        check(25'(sdo_line), 25'd1, "driven with strobe high");
        repeat (6) @(posedge core_clk_in);
        host.shift_in(14, w);
        check(w, 25'h2001, "no-busy word");
        repeat (4) @(posedge core_clk_in);
        check(25'(sdo_line), 25'd1, "no float at 14th fall");
        $display("no-busy mode done");
    endtask : test_nobusy

    task automatic test_accum;
        host.set_mode(1'b0);
        code <= 14'h1FFF;
        host.convert(2);
        wait_idle();
        code <= 14'h0003;
        host.convert(8);
        check(25'(sdo_line), 25'd1, "busy bit kept at strobe");
        wait_idle();
        host.shift_in(16, w);
        check(w, 25'h2002, "two-sample sum");
        repeat (4) @(posedge core_clk_in);
        check(25'(sdo_line), 25'd1, "no float after sum");
        $display("accumulate done");
    endtask : test_accum

    task automatic test_recal;
        int k;
        host.convert(2);
        wait_idle();
        host.shift_in(1024, w);
        check(25'(cal_busy), 25'd1, "no recalibration");
        check(25'(sdo_line), 25'd0, "line not low");
        for (k = 0; k < CAL + 50 && cal_busy !== 1'b0; k++)
            @(posedge core_clk_in);
        check(25'(k < CAL + 50), 25'd1, "recalibration hang");
        repeat (3) @(posedge core_clk_in);
        check(25'(sdo_line), 25'd1, "line not released");
        $display("recalibrate done");
    endtask : test_recal

    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // hang guard, well past the 1024-pulse burst
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n_in = 1'b0;
        code = '0;
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        test_busy();
        test_nobusy();
        test_accum();
        test_recal();
        tally_and_finish();
    end
endmodule : testbench
